/* File: scpr_regs.svh */
// register offsets, reset values, field positions and counts
`ifndef SCPR_REGS_SVH
`define SCPR_REGS_SVH

// ***********************************************************************
// register offsets
// ***********************************************************************
`define SCPR_ADDR_PORT      13'h0000
`define SCPR_ADDR_ID        13'h0003
`define SCPR_ADDR_RBSEL     13'h0004
`define SCPR_ADDR_OSCDIV    13'h01E0
`define SCPR_ADDR_INCLK     13'h01E1
`define SCPR_ADDR_PDSYNC    13'h0230
`define SCPR_ADDR_RSVD      13'h0231
`define SCPR_ADDR_UPDATE    13'h0232
`define SCPR_ADDR_STEP      13'h0001

// ***********************************************************************
// reset values
// ***********************************************************************
`define SCPR_RST_PORT       8'h18
`define SCPR_RST_RBSEL      8'h00
`define SCPR_RST_OSCDIV     8'h02
`define SCPR_RST_INCLK      8'h00
`define SCPR_RST_PDSYNC     8'h00
`define SCPR_RST_ZERO       8'h00

// ***********************************************************************
// field positions
// ***********************************************************************
`define SCPR_BIT_SDO_ACTIVE 0
`define SCPR_BIT_LSB_FIRST  1
`define SCPR_BIT_SOFT_RESET 2
`define SCPR_BIT_LONG_INSTR 3
`define SCPR_BIT_RB_ACTIVE  0
`define SCPR_BIT_UPDATE     0
`define SCPR_INSTR_RW       15
`define SCPR_INSTR_LEN_HI   14
`define SCPR_INSTR_LEN_LO   13
`define SCPR_INSTR_ADDR_HI  12

// ***********************************************************************
// buffered register slots
// ***********************************************************************
`define SCPR_IDX_RBSEL      2'h0
`define SCPR_IDX_OSCDIV     2'h1
`define SCPR_IDX_INCLK      2'h2
`define SCPR_IDX_PDSYNC     2'h3

// ***********************************************************************
// transfer counts
// ***********************************************************************
`define SCPR_INSTR_BITS     5'h10
`define SCPR_BYTE_BITS      5'h08
`define SCPR_BIT_STEP       5'h01
`define SCPR_LEN_STREAM     2'h3
`define SCPR_LEN_STEP       2'h1
`define SCPR_BIT_TOP        3'h7

`endif

/* File: scpr_pkg.sv */
// types of the serial port configuration register block
package scpr_pkg;

  // ***********************************************************************
  // transfer phase
  // ***********************************************************************
  typedef enum logic [3:0] {
    SCPR_IDLE  = 4'b0001,
    SCPR_INSTR = 4'b0010,
    SCPR_DATA  = 4'b0100,
    SCPR_DONE  = 4'b1000
  } scpr_phase_t;

  // ***********************************************************************
  // active settings that steer the clock path
  // ***********************************************************************
  typedef struct packed {
    logic [7:0] oscDivider;
    logic [7:0] inputClock;
    logic [7:0] powerdownSync;
  } scpr_active_t;

  // ***********************************************************************
  // whole module state
  // ***********************************************************************
  typedef struct packed {
    logic [1:0]      sclkSync;
    logic [1:0]      csnSync;
    logic [1:0]      dataSync;
    logic            sclkPrev;
    scpr_phase_t     phase;
    logic [4:0]      bitCnt;
    logic [15:0]     shift;
    logic            isRead;
    logic [1:0]      lenCode;
    logic [1:0]      bytesLeft;
    logic [12:0]     addr;
    logic [7:0]      tx;
    logic [7:0]      portCfg;
    logic [3:0][7:0] bufRegs;
    logic [3:0][7:0] actRegs;
    logic            dataIoOut;
    logic            dataIoOe;
    logic            sdoOut;
    logic            sdoOe;
  } scpr_state_t;

endpackage : scpr_pkg

/* File: scpr_serial_port.sv */
// serial control port with its configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "scpr_regs.svh"

module scpr_serial_port
  import scpr_pkg::*;
#(
  parameter logic [7:0] VARIANT_ID = 8'h5A  // arbitrary value
) (
  input  wire logic   sys_clk,
  input  wire logic   resetn,
  input  wire logic   sclk,
  input  wire logic   csn,
  input  wire logic   dataIoIn,
  output logic        dataIoOut,
  output logic        dataIoOe,
  output logic        serialDataOutputPin,
  output logic        serialDataOutputPinOe,
  output logic [7:0]  portConfig,
  output scpr_active_t activeRegs
);

  scpr_state_t st_r;
  scpr_state_t st_nxt;

  // ***********************************************************************
  // register access helpers
  // ***********************************************************************
  function automatic logic [1:0] slotOf(input logic [12:0] a);
    logic [1:0] idx;
    idx = `SCPR_IDX_RBSEL;
    if (a == `SCPR_ADDR_OSCDIV) begin
      idx = `SCPR_IDX_OSCDIV;
    end else if (a == `SCPR_ADDR_INCLK) begin
      idx = `SCPR_IDX_INCLK;
    end else if (a == `SCPR_ADDR_PDSYNC) begin
      idx = `SCPR_IDX_PDSYNC;
    end
    return idx;
  endfunction : slotOf

  function automatic logic isBuffered(input logic [12:0] a);
    return (a == `SCPR_ADDR_RBSEL) || (a == `SCPR_ADDR_OSCDIV) ||
           (a == `SCPR_ADDR_INCLK) || (a == `SCPR_ADDR_PDSYNC);
  endfunction : isBuffered

  function automatic logic [7:0] readReg(input scpr_state_t s,
                                         input logic [12:0] a);
    logic [7:0] d;
    logic       useAct;
    d      = `SCPR_RST_ZERO;
    useAct = s.actRegs[`SCPR_IDX_RBSEL][`SCPR_BIT_RB_ACTIVE];
    if (a == `SCPR_ADDR_PORT) begin
      d = s.portCfg;
    end else if (a == `SCPR_ADDR_ID) begin
      d = VARIANT_ID;
    end else if (isBuffered(a)) begin
      d = useAct ? s.actRegs[slotOf(a)] : s.bufRegs[slotOf(a)];
    end
    return d;
  endfunction : readReg

  function automatic scpr_state_t writeReg(input scpr_state_t s,
                                           input logic [12:0] a,
                                           input logic [7:0]  d);
    scpr_state_t n;
    n = s;
    if (a == `SCPR_ADDR_PORT) begin
      n.portCfg = d;
    end else if (isBuffered(a)) begin
      n.bufRegs[slotOf(a)] = d;
    end else if (a == `SCPR_ADDR_UPDATE) begin
      if (d[`SCPR_BIT_UPDATE]) begin
        n.actRegs = s.bufRegs;
      end
    end
    return n;
  endfunction : writeReg

  function automatic logic [15:0] shiftIn(input logic [15:0] sh,
                                          input logic        b,
                                          input logic        lsb);
    return lsb ? {b, sh[15:1]} : {sh[14:0], b};
  endfunction : shiftIn

  // ***********************************************************************
  // next state
  // ***********************************************************************
  logic       lsbFirst;
  logic       sdoActive;
  logic       sclkRise;
  logic       sclkFall;
  logic       csActive;
  logic       sdata;
  logic [4:0] cntInc;
  logic [7:0] rxByte;
  logic       outBit;
  logic [2:0] outIdx;

  always_comb begin
    st_nxt    = st_r;
    lsbFirst  = st_r.portCfg[`SCPR_BIT_LSB_FIRST];
    sdoActive = st_r.portCfg[`SCPR_BIT_SDO_ACTIVE];
    sclkRise  = st_r.sclkSync[1] && !st_r.sclkPrev;
    sclkFall  = !st_r.sclkSync[1] && st_r.sclkPrev;
    csActive  = !st_r.csnSync[1];
    sdata     = st_r.dataSync[1];
    cntInc    = st_r.bitCnt + `SCPR_BIT_STEP;
    rxByte    = lsbFirst ? st_nxt.shift[15:8] : st_nxt.shift[7:0];
    outIdx    = lsbFirst ? st_r.bitCnt[2:0]
                         : `SCPR_BIT_TOP - st_r.bitCnt[2:0];
    outBit    = st_r.tx[outIdx];

    st_nxt.sclkSync = {st_r.sclkSync[0], sclk};
    st_nxt.csnSync  = {st_r.csnSync[0], csn};
    st_nxt.dataSync = {st_r.dataSync[0], dataIoIn};
    st_nxt.sclkPrev = st_r.sclkSync[1];

    if (!csActive) begin
      st_nxt.phase     = SCPR_IDLE;
      st_nxt.bitCnt    = '0;
      st_nxt.dataIoOe  = 1'b0;
      st_nxt.sdoOe     = 1'b0;
    end else begin
      case (st_r.phase)
        SCPR_IDLE, SCPR_INSTR: begin
          st_nxt.phase = SCPR_INSTR;
          if (sclkRise) begin
            st_nxt.shift  = shiftIn(st_r.shift, sdata, lsbFirst);
            st_nxt.bitCnt = cntInc;
            if (cntInc == `SCPR_INSTR_BITS) begin
              st_nxt.isRead    = st_nxt.shift[`SCPR_INSTR_RW];
              st_nxt.lenCode   = st_nxt.shift[`SCPR_INSTR_LEN_HI:
                                              `SCPR_INSTR_LEN_LO];
              st_nxt.bytesLeft = st_nxt.lenCode;
              st_nxt.addr      = st_nxt.shift[`SCPR_INSTR_ADDR_HI:0];
              st_nxt.tx        = readReg(st_r, st_nxt.addr);
              st_nxt.bitCnt    = '0;
              st_nxt.phase     = SCPR_DATA;
            end
          end
        end
        SCPR_DATA: begin
          if (sclkRise) begin
            st_nxt.shift  = shiftIn(st_r.shift, sdata, lsbFirst);
            rxByte        = lsbFirst ? st_nxt.shift[15:8]
                                     : st_nxt.shift[7:0];
            st_nxt.bitCnt = cntInc;
            if (cntInc == `SCPR_BYTE_BITS) begin
              if (!st_r.isRead) begin
                st_nxt = writeReg(st_nxt, st_r.addr, rxByte);
              end
              st_nxt.addr   = lsbFirst ? st_r.addr + `SCPR_ADDR_STEP
                                       : st_r.addr - `SCPR_ADDR_STEP;
              st_nxt.tx     = readReg(st_nxt, st_nxt.addr);
              st_nxt.bitCnt = '0;
              if (st_r.lenCode != `SCPR_LEN_STREAM) begin
                if (st_r.bytesLeft == 2'h0) begin
                  st_nxt.phase = SCPR_DONE;
                end else begin
                  st_nxt.bytesLeft = st_r.bytesLeft - `SCPR_LEN_STEP;
                end
              end
            end
          end
          if (sclkFall && st_r.isRead) begin
            if (sdoActive) begin
              st_nxt.sdoOut   = outBit;
              st_nxt.sdoOe    = 1'b1;
              st_nxt.dataIoOe = 1'b0;
            end else begin
              st_nxt.dataIoOut = outBit;
              st_nxt.dataIoOe  = 1'b1;
              st_nxt.sdoOe     = 1'b0;
            end
          end
        end
        SCPR_DONE: begin
          if (sclkFall) begin
            st_nxt.dataIoOe = 1'b0;
            st_nxt.sdoOe    = 1'b0;
          end
        end
        default: begin
          st_nxt.phase = SCPR_IDLE;
        end
      endcase
    end

    if (st_nxt.portCfg[`SCPR_BIT_SOFT_RESET]) begin
      st_nxt.bufRegs[`SCPR_IDX_RBSEL]  = `SCPR_RST_RBSEL;
      st_nxt.bufRegs[`SCPR_IDX_OSCDIV] = `SCPR_RST_OSCDIV;
      st_nxt.bufRegs[`SCPR_IDX_INCLK]  = `SCPR_RST_INCLK;
      st_nxt.bufRegs[`SCPR_IDX_PDSYNC] = `SCPR_RST_PDSYNC;
      st_nxt.actRegs                   = st_nxt.bufRegs;
    end
  end

  // ***********************************************************************
  // state register
  // ***********************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r                          <= '0;
      st_r.csnSync                  <= 2'h3;
      st_r.phase                    <= SCPR_IDLE;
      st_r.portCfg                  <= `SCPR_RST_PORT;
      st_r.bufRegs[`SCPR_IDX_OSCDIV] <= `SCPR_RST_OSCDIV;
      st_r.actRegs[`SCPR_IDX_OSCDIV] <= `SCPR_RST_OSCDIV;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign dataIoOut             = st_r.dataIoOut;
  assign dataIoOe              = st_r.dataIoOe;
  assign serialDataOutputPin   = st_r.sdoOut;
  assign serialDataOutputPinOe = st_r.sdoOe;
  assign portConfig            = st_r.portCfg;
  assign activeRegs.oscDivider    = st_r.actRegs[`SCPR_IDX_OSCDIV];
  assign activeRegs.inputClock    = st_r.actRegs[`SCPR_IDX_INCLK];
  assign activeRegs.powerdownSync = st_r.actRegs[`SCPR_IDX_PDSYNC];

endmodule : scpr_serial_port
`default_nettype wire

/* File: scpr_chk.sv */
// assertion checker for the serial port register block
`timescale 1ns/1ns
`default_nettype none
module scpr_chk
  import scpr_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         resetn,
  input wire logic         sclk,
  input wire logic         csn,
  input wire logic         dataIoIn,
  input wire logic         dataIoOut,
  input wire logic         dataIoOe,
  input wire logic         serialDataOutputPin,
  input wire logic         serialDataOutputPinOe,
  input wire logic [7:0]   portConfig,
  input wire scpr_active_t activeRegs
);
  // ***********************************************************************
  // properties
  // ***********************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  AST_OE_EXCL: assert property (!(dataIoOe && serialDataOutputPinOe))
    else $error("both data pins driven");
  AST_SDO_FLOAT: assert property (!portConfig[0] |-> !serialDataOutputPinOe)
    else $error("output pin driven in bidirectional mode");
  AST_OE_IDLE: assert property (csn[*8] |-> !dataIoOe && !serialDataOutputPinOe)
    else $error("pin driven outside frame");
  AST_SOFT_RST: assert property (portConfig[2][*2] |-> activeRegs == 24'h020000)
    else $error("active regs not at defaults in soft reset");
  AST_ACT_STABLE: assert property (csn[*6] |=> $stable(activeRegs))
    else $error("active regs changed outside frame");
  AST_CFG_STABLE: assert property (csn[*6] |=> $stable(portConfig))
    else $error("port config changed outside frame");
  AST_LONG_MODE: assert property (portConfig[3])
    else $error("long instruction bit low");
  AST_BIT_HOLD: assert property (dataIoOe && $rose(sclk) |-> ##2 $stable(dataIoOut)[*3])
    else $error("read bit changed while clock high");
endmodule : scpr_chk
bind scpr_serial_port scpr_chk chk (.sys_clk(sys_clk), .resetn(resetn),
  .sclk(sclk), .csn(csn), .dataIoIn(dataIoIn), .dataIoOut(dataIoOut),
  .dataIoOe(dataIoOe), .serialDataOutputPin(serialDataOutputPin),
  .serialDataOutputPinOe(serialDataOutputPinOe),
  .portConfig(portConfig), .activeRegs(activeRegs));
`default_nettype wire

/* File: scpr_host.sv */
// host controller model driving the serial port
`timescale 1ns/1ns
`default_nettype none
module scpr_host (
  input  wire logic sys_clk,
  input  wire logic dioWire,
  input  wire logic dioOe,
  input  wire logic serial_data_output_pin,
  input  wire logic sdoOe,
  output logic      sclk,
  output logic      csn,
  output logic      dio
);
  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    dio = 1'b0;
  end
  // one frame: 16-bit instruction then nb bytes, first byte in wd[7:0]
  task automatic frame(input logic [15:0] ins, input logic [23:0] wd,
                       input int nb, input logic lsb, input logic uni,
                       output logic [23:0] rd);
    int k;
    int x;
    rd = 24'h000000;
    @(negedge sys_clk);
    csn = 1'b0;
    for (int i = 0; i < 16 + 8 * nb; i++) begin
      k = i - 16;
      x = (k / 8) * 8 + (lsb ? k % 8 : 7 - k % 8);
      if (i < 16)
        dio = ins[lsb ? i : 15 - i];
      else if (!ins[15])
        dio = wd[x];
      else
        dio = ~dio;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
      repeat (4) @(negedge sys_clk);
      if (i >= 16)
        rd[x] = uni ? (sdoOe ? serial_data_output_pin : 1'bx) : (dioOe ? dioWire : 1'bx);
      sclk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    csn = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask : frame
endmodule : scpr_host
`default_nettype wire

/* File: serial_port_config_registers_bench.sv */
// self-checking bench for the serial port register block
`timescale 1ns/1ns
`default_nettype none
module serial_port_config_registers_bench;
  import scpr_pkg::*;
  localparam logic [7:0] VID = 8'hA5;  // arbitrary value
  logic         sys_clk;
  logic         resetn;
  logic         lsbM;
  logic         uniM;
  logic [23:0]  d;
  int           errors;
  int           n_tests;
  wire logic    sclk;
  wire logic    csn;
  wire logic    hostDio;
  wire logic    dioWire;
  wire logic    dataIoOut;
  wire logic    dataIoOe;
  wire logic    serial_data_output_pin;
  wire logic    sdoOe;
  wire logic [7:0] portConfig;
  scpr_active_t activeRegs;
  assign dioWire = dataIoOe ? dataIoOut : hostDio;
  scpr_serial_port #(.VARIANT_ID(VID)) dut (.sys_clk(sys_clk),
    .resetn(resetn), .sclk(sclk), .csn(csn), .dataIoIn(dioWire),
    .dataIoOut(dataIoOut), .dataIoOe(dataIoOe), .serialDataOutputPin(serial_data_output_pin),
    .serialDataOutputPinOe(sdoOe), .portConfig(portConfig),
    .activeRegs(activeRegs));
  scpr_host host (.sys_clk(sys_clk), .dioWire(dioWire), .dioOe(dataIoOe),
    .serial_data_output_pin(serial_data_output_pin), .sdoOe(sdoOe), .sclk(sclk), .csn(csn), .dio(hostDio));
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;
  // ***********************************************************************
  // tasks
  // ***********************************************************************
  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic rw, input logic [12:0] a, input int nb,
                      input logic [15:0] wd);
    logic [23:0] r;
    host.frame({rw, 2'(nb - 1), a}, {8'h00, wd}, nb, lsbM, uniM, r);
    d = r;
  endtask : xfer
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // ***********************************************************************
  // tests
  // ***********************************************************************
  initial begin
    #2000000;
    errors++;
    report_and_stop();
  end
  initial begin
    errors = 0;
    n_tests = 0;
    lsbM = 1'b0;
    uniM = 1'b0;
    resetn = 1'b0;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("cfg", 24'h000018, {16'h0000, portConfig});
    chk("act", 24'h020000, activeRegs);
    xfer(1'b1, 13'h0003, 1, 16'h0000);
    chk("id", {16'h0000, VID}, d);
    xfer(1'b0, 13'h0003, 1, 16'h00FF);
    xfer(1'b1, 13'h0003, 1, 16'h0000);
    chk("id", {16'h0000, VID}, d);
    xfer(1'b0, 13'h01E0, 1, 16'h0005);
    chk("act", 24'h020000, activeRegs);
    xfer(1'b1, 13'h01E0, 1, 16'h0000);
    chk("buf", 24'h000005, d);
    xfer(1'b0, 13'h0232, 1, 16'h0001);
    chk("act", 24'h050000, activeRegs);
    xfer(1'b1, 13'h0232, 1, 16'h0000);
    chk("upd", 24'h000000, d);
    xfer(1'b0, 13'h0004, 1, 16'h0001);
    xfer(1'b0, 13'h0232, 1, 16'h0001);
    xfer(1'b0, 13'h01E0, 1, 16'h0007);
    xfer(1'b1, 13'h01E0, 1, 16'h0000);
    chk("active", 24'h000005, d);
    xfer(1'b1, 13'h0004, 2, 16'h0000);
    chk("dec", {8'h00, VID, 8'h01}, d);
    xfer(1'b0, 13'h0000, 1, 16'h0099);
    uniM = 1'b1;
    chk("cfg", 24'h000099, {16'h0000, portConfig});
    xfer(1'b1, 13'h0003, 1, 16'h0000);
    chk("sdo", {16'h0000, VID}, d);
    xfer(1'b0, 13'h0000, 1, 16'h005A);
    lsbM = 1'b1;
    uniM = 1'b0;
    xfer(1'b1, 13'h0003, 2, 16'h0000);
    chk("inc", {8'h00, 8'h01, VID}, d);
    xfer(1'b0, 13'h0000, 1, 16'h0018);
    lsbM = 1'b0;
    chk("cfg", 24'h000018, {16'h0000, portConfig});
    xfer(1'b0, 13'h0000, 1, 16'h003C);
    chk("soft", 24'h020000, activeRegs);
    xfer(1'b0, 13'h0000, 1, 16'h0018);
    xfer(1'b1, 13'h01E0, 1, 16'h0000);
    chk("soft", 24'h000002, d);
    xfer(1'b0, 13'h01E1, 2, 16'h0913);
    xfer(1'b0, 13'h0230, 1, 16'h0006);
    chk("act", 24'h020000, activeRegs);
    xfer(1'b1, 13'h01E1, 3, 16'h0000);
    chk("three", 24'h000913, d);
    xfer(1'b0, 13'h0232, 1, 16'h0001);
    chk("act", 24'h091306, activeRegs);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("rst", 24'h020000, activeRegs);
    xfer(1'b1, 13'h01E0, 1, 16'h0000);
    chk("rst", 24'h000002, d);
    report_and_stop();
  end
endmodule : serial_port_config_registers_bench
`default_nettype wire
